//--- core/clock_out_divider.sv
// Purpose : divides the reference clock for the clock output pin
// Assumes : div_sel codes 1..6 divide by 2..64
// Notes   : wave is held low while stopped so the pin starts clean
`timescale 1ns/10ps
`include "ref_clock_consts.svh"
module clock_out_divider (
    input  wire logic clock,
    input  wire logic rst,
    synth_link_if.div link
);
    logic [5:0] count_r;
    logic       wave_r;
    logic       wave_nxt;

    // ------------------------------------------------------------------
    // pick the counter bit that toggles at the chosen rate
    // ------------------------------------------------------------------
    always_comb begin
        wave_nxt = 1'b0;
        case (link.div_sel)
            3'h1:    wave_nxt = count_r[0];
            3'h2:    wave_nxt = count_r[1];
            3'h3:    wave_nxt = count_r[2];
            3'h4:    wave_nxt = count_r[3];
            3'h5:    wave_nxt = count_r[4];
            3'h6:    wave_nxt = count_r[5];
            default: wave_nxt = 1'b0;
        endcase
    end

    // free counter, cleared while stopped
    always_ff @(posedge clock) begin
        if (rst || !link.div_run) begin
            count_r <= 6'h00;
            wave_r  <= 1'b0;
        end else begin
            count_r <= count_r + 6'h01;
            wave_r  <= wave_nxt;
        end
    end

    assign link.div_wave = wave_r;
endmodule // clock_out_divider

//--- core/ref_clock_and_synth_control.sv
// Purpose : reference clock, vco calibration and carrier word control
// Assumes : apb slave with zero wait states; pins synchronous to clock
// Notes   : full-rate clock output is given as a gate enable, since the
//           reference itself cannot pass through a flip-flop
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "ref_clock_consts.svh"

// Function
// - raise low battery interrupt when supply falls below programmed threshold.
// - low battery interrupt may be routed to any io pin by mapping.
// - with sequencer on, start pll automatically once oscillator is stable.
// - clock output only after stable oscillation; host waits otherwise.
// - pin five carries reference or a divided fraction, chosen by select.
// - clock output works in all modes but is forced off in sleep.
// - clock output select resets to an enabled setting.
// - coarse vco calibration after reset, fine one each pll activation.
// - synthesizer step is reference divided by two to the nineteen.
// - carrier is step times 24-bit word in three byte registers.
// - new carrier applies only when the low byte is written.
// - pll lock raised in locking range, mappable onto io pins.
module ref_clock_and_synth_control (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        xtal_stable,
    input  wire logic        sleep_mode,
    input  wire logic        pll_request,
    input  wire logic        pll_in_range,
    input  wire logic [7:0]  supply_level,
    input  wire logic [5:0]  io_in,
    output logic      [5:0]  io_out,
    output logic      [5:0]  io_oe_n,
    output logic             ref_clock_output_gate,
    output logic             ext_clock_select,
    output logic             pll_start,
    output logic             vco_coarse_cal,
    output logic             vco_fine_cal,
    output logic      [4:0]  synth_int,
    output logic      [18:0] synth_frac,
    output logic             pll_lock,
    output logic             low_battery_irq
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    synth_link_if link ();

    ref_clock_pkg::synth_state_type state_r;
    ref_clock_pkg::synth_state_type state_nxt;

    logic [7:0]  carrier_msb_r;
    logic [7:0]  carrier_mid_r;
    logic [23:0] carrier_word_r;
    logic [7:0]  ext_clock_r;
    logic [1:0]  control_r;
    logic [8:0]  low_battery_r;
    logic [11:0] io_map_r;
    logic [2:0]  reference_clock_output_sel_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        coarse_done_r;
    logic        low_battery_r_level;
    logic        lock_r;
    logic [5:0]  io_out_r;
    logic [5:0]  io_oe_n_r;
    logic        gate_r;

    logic        setup_phase;
    logic        wr_en;
    logic [9:0]  index;
    logic        addr_ok;
    logic        pll_wanted;
    logic        clock_allowed;
    logic        reference_clock_output_divided;
    logic [31:0] read_value;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // known register index check, shared by read and error decode
    function automatic logic index_known(input logic [9:0] idx);
        index_known = (idx == `IDX_CARRIER_MSB) || (idx == `IDX_CARRIER_MID) ||
                      (idx == `IDX_CARRIER_LSB) || (idx == `IDX_EXT_CLOCK) ||
                      (idx == `IDX_SYNTH_CONTROL) || (idx == `IDX_STATUS) ||
                      (idx == `IDX_LOW_BATTERY) || (idx == `IDX_IO_MAP) ||
                      (idx == `IDX_IO_MAP_SECOND);
    endfunction

    // write to one register index, the byte lane given by the caller required
    function automatic logic write_hit(input logic en, input logic [9:0] idx,
                                       input logic [9:0] target, input logic lane);
        write_hit = en && (idx == target) && lane;
    endfunction

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // read data and error are captured in the setup cycle so the access
    // phase returns flop outputs with no wait states
    assign index       = paddr[11:2];
    assign addr_ok     = (paddr[1:0] == 2'h0) && index_known(index);
    assign setup_phase = psel && !penable;
    assign wr_en       = psel && penable && pwrite && addr_ok;

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (setup_phase) begin
            prdata_r  <= (pwrite || !addr_ok) ? 32'h00000000 : read_value;
            pslverr_r <= !addr_ok;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = pslverr_r && psel && penable;

    // ------------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        read_value = 32'h00000000;
        case (index)
            `IDX_CARRIER_MSB:   read_value = {24'h000000, carrier_msb_r};
            `IDX_CARRIER_MID:   read_value = {24'h000000, carrier_mid_r};
            `IDX_CARRIER_LSB:   read_value = {24'h000000, carrier_word_r[7:0]};
            `IDX_EXT_CLOCK:     read_value = {24'h000000, ext_clock_r};
            `IDX_SYNTH_CONTROL: read_value = {30'h00000000, control_r};
            `IDX_STATUS:        read_value = {18'h00000, io_in, 2'h0, low_battery_r_level,
                                              lock_r, link.cal_busy, coarse_done_r,
                                              pll_start, xtal_stable};
            `IDX_LOW_BATTERY:   read_value = {23'h000000, low_battery_r};
            `IDX_IO_MAP:        read_value = {18'h00000, io_map_r[11:6], 2'h0, io_map_r[5:0]};
            `IDX_IO_MAP_SECOND: read_value = {29'h00000000, reference_clock_output_sel_r};
            default:            read_value = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // carrier frequency word
    // ------------------------------------------------------------------
    // upper bytes land in shadow flops; the synthesizer only ever sees
    // carrier_word_r, so a half-written word can never glitch the lo
    always_ff @(posedge clock) begin
        if (rst) begin
            carrier_msb_r  <= 8'(`CARRIER_RESET >> 16);
            carrier_mid_r  <= 8'(`CARRIER_RESET >> 8);
            carrier_word_r <= `CARRIER_RESET;
        end else begin
            if (write_hit(wr_en, index, `IDX_CARRIER_MSB, pstrb[0])) begin
                carrier_msb_r <= pwdata[7:0];
            end
            if (write_hit(wr_en, index, `IDX_CARRIER_MID, pstrb[0])) begin
                carrier_mid_r <= pwdata[7:0];
            end
            if (write_hit(wr_en, index, `IDX_CARRIER_LSB, pstrb[0])) begin
                carrier_word_r <= {carrier_msb_r, carrier_mid_r, pwdata[7:0]};
            end
        end
    end

    // integer part above the fractional modulator, fraction below it
    assign synth_int  = carrier_word_r[23:`SYNTH_FRAC_BITS];
    assign synth_frac = carrier_word_r[`SYNTH_FRAC_BITS-1:0];

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            ext_clock_r   <= `EXT_CLOCK_RESET;
            control_r     <= `CTRL_RESET;
            low_battery_r <= `LOWBAT_RESET;
            io_map_r      <= `IO_MAP_RESET;
            reference_clock_output_sel_r  <= `REFERENCE_CLOCK_OUTPUT_SEL_RESET;
        end else begin
            if (write_hit(wr_en, index, `IDX_EXT_CLOCK, pstrb[0])) begin
                ext_clock_r <= pwdata[7:0];
            end
            if (write_hit(wr_en, index, `IDX_SYNTH_CONTROL, pstrb[0])) begin
                control_r <= pwdata[1:0];
            end
            if (write_hit(wr_en, index, `IDX_LOW_BATTERY, pstrb[0])) begin
                low_battery_r[7:0] <= pwdata[7:0];
            end
            if (write_hit(wr_en, index, `IDX_LOW_BATTERY, pstrb[1])) begin
                low_battery_r[8] <= pwdata[`LOWBAT_ENABLE_BIT];
            end
            if (write_hit(wr_en, index, `IDX_IO_MAP, pstrb[0])) begin
                io_map_r[5:0] <= pwdata[5:0];
            end
            if (write_hit(wr_en, index, `IDX_IO_MAP, pstrb[1])) begin
                io_map_r[11:6] <= pwdata[13:8];
            end
            if (write_hit(wr_en, index, `IDX_IO_MAP_SECOND, pstrb[0])) begin
                reference_clock_output_sel_r <= pwdata[2:0];
            end
        end
    end

    // the external reference itself is the host's to supply
    assign ext_clock_select = ext_clock_r[`EXT_CLOCK_BIT];

    // ------------------------------------------------------------------
    // synthesizer sequence
    // ------------------------------------------------------------------
    // with the sequencer off the host must already have waited for the
    // oscillator; the manual bit starts the pll from st_idle, with xtal_stable high and sleep_mode low
    assign pll_wanted = control_r[`CTRL_SEQUENCER_BIT] ?
                        (pll_request && !sleep_mode) :
                        (control_r[`CTRL_MANUAL_PLL_BIT] && !sleep_mode);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ref_clock_pkg::st_osc_wait: begin
                if (xtal_stable) begin
                    state_nxt = coarse_done_r ? ref_clock_pkg::st_idle : ref_clock_pkg::st_coarse;
                end
            end
            ref_clock_pkg::st_coarse: begin
                if (link.cal_done) begin
                    state_nxt = ref_clock_pkg::st_idle;
                end
            end
            ref_clock_pkg::st_idle: begin
                if (!xtal_stable) begin
                    state_nxt = ref_clock_pkg::st_osc_wait;
                end else if (pll_wanted) begin
                    state_nxt = ref_clock_pkg::st_fine;
                end
            end
            ref_clock_pkg::st_fine: begin
                if (link.cal_done) begin
                    state_nxt = ref_clock_pkg::st_run;
                end
            end
            ref_clock_pkg::st_run: begin
                if (!xtal_stable) begin
                    state_nxt = ref_clock_pkg::st_osc_wait;
                end else if (!pll_wanted) begin
                    state_nxt = ref_clock_pkg::st_idle;
                end
            end
            default: state_nxt = ref_clock_pkg::st_osc_wait;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= ref_clock_pkg::st_osc_wait;
        end else begin
            state_r <= state_nxt;
        end
    end

    // coarse calibration runs once per reset; remembered across xtal loss
    always_ff @(posedge clock) begin
        if (rst) begin
            coarse_done_r <= 1'b0;
        end else if (state_r == ref_clock_pkg::st_coarse && link.cal_done) begin
            coarse_done_r <= 1'b1;
        end
    end

    // calibration start pulses on entry to either calibration state
    assign link.cal_start = (state_r != state_nxt) &&
                            (state_nxt == ref_clock_pkg::st_coarse ||
                             state_nxt == ref_clock_pkg::st_fine);
    assign link.cal_fine  = (state_nxt == ref_clock_pkg::st_fine);

    assign pll_start      = (state_r == ref_clock_pkg::st_fine) || (state_r == ref_clock_pkg::st_run);
    assign vco_coarse_cal = (state_r == ref_clock_pkg::st_coarse);
    assign vco_fine_cal   = (state_r == ref_clock_pkg::st_fine);

    vco_cal_timer u_cal (
        .clock (clock),
        .rst   (rst),
        .link  (link.cal)
    );

    // ------------------------------------------------------------------
    // lock and low battery indications
    // ------------------------------------------------------------------
    // lock follows the next state, so it never outlives pll_start
    always_ff @(posedge clock) begin
        if (rst) begin
            lock_r              <= 1'b0;
            low_battery_r_level <= 1'b0;
        end else begin
            lock_r              <= (state_nxt == ref_clock_pkg::st_run) && pll_in_range;
            low_battery_r_level <= low_battery_r[8] && (supply_level < low_battery_r[7:0]);
        end
    end

    assign pll_lock        = lock_r;
    assign low_battery_irq = low_battery_r_level;

    // ------------------------------------------------------------------
    // clock output
    // ------------------------------------------------------------------
    // nothing leaves the pin until the oscillator is stable, and sleep
    // forces it off whatever the select holds
    assign clock_allowed  = xtal_stable && !sleep_mode &&
                            (reference_clock_output_sel_r != `REFERENCE_CLOCK_OUTPUT_SEL_OFF);
    assign reference_clock_output_divided = clock_allowed && (reference_clock_output_sel_r != `REFERENCE_CLOCK_OUTPUT_SEL_FULL);
    assign link.div_sel   = reference_clock_output_sel_r;
    assign link.div_run   = reference_clock_output_divided;

    clock_out_divider u_div (
        .clock (clock),
        .rst   (rst),
        .link  (link.div)
    );

    // ------------------------------------------------------------------
    // io pin routing
    // ------------------------------------------------------------------
    // pin five belongs to the clock output while it runs; elsewhere each
    // pin shows the or of the events mapped onto it
    always_ff @(posedge clock) begin
        if (rst) begin
            io_out_r  <= 6'h00;
            io_oe_n_r <= 6'h3f;
            gate_r    <= 1'b0;
        end else begin
            gate_r <= clock_allowed && (reference_clock_output_sel_r == `REFERENCE_CLOCK_OUTPUT_SEL_FULL);
            for (int pin = 0; pin < 6; pin++) begin
                io_out_r[pin]  <= (io_map_r[pin] && low_battery_r_level) ||
                                  (io_map_r[pin + 6] && lock_r);
                io_oe_n_r[pin] <= !(io_map_r[pin] || io_map_r[pin + 6]);
            end
            if (clock_allowed) begin
                io_out_r[5]  <= 1'b0;
                io_oe_n_r[5] <= 1'b0;
            end
        end
    end

    // divided wave goes straight from its flop to the pin
    assign io_out                = {reference_clock_output_divided ? link.div_wave : io_out_r[5], io_out_r[4:0]};
    assign io_oe_n               = io_oe_n_r;
    assign ref_clock_output_gate = gate_r;

endmodule // ref_clock_and_synth_control

//--- core/ref_clock_consts.svh
// Purpose : offsets, field positions, reset values and timing counts
// Assumes : 32-bit apb data, one register per aligned word
// Notes   : register indices are multiplied by four to give byte addresses
`ifndef REF_CLOCK_CONSTS_SVH
`define REF_CLOCK_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define IDX_CARRIER_MSB      10'h007
`define IDX_CARRIER_MID      10'h008
`define IDX_CARRIER_LSB      10'h009
`define IDX_EXT_CLOCK        10'h059
`define IDX_SYNTH_CONTROL    10'h060
`define IDX_STATUS           10'h061
`define IDX_LOW_BATTERY      10'h062
`define IDX_IO_MAP           10'h063
`define IDX_IO_MAP_SECOND    10'h064

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define EXT_CLOCK_BIT        4
`define CTRL_SEQUENCER_BIT   0
`define CTRL_MANUAL_PLL_BIT  1
`define LOWBAT_ENABLE_BIT    8
`define SYNTH_FRAC_BITS      19
`define REFERENCE_CLOCK_OUTPUT_SEL_FULL      3'h0
`define REFERENCE_CLOCK_OUTPUT_SEL_OFF       3'h7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CARRIER_RESET        24'h000000
`define EXT_CLOCK_RESET      8'h00
`define CTRL_RESET           2'h1
`define LOWBAT_RESET         9'h000
`define IO_MAP_RESET         12'h000
`define REFERENCE_CLOCK_OUTPUT_SEL_RESET     3'h0

// ----------------------------------------------------------------------
// timing: times in ns, cycles derived from the clock period
// ----------------------------------------------------------------------
`define CLOCK_PERIOD_NS      10
`define COARSE_CAL_NS        40000
`define FINE_CAL_NS          10000
`define COARSE_CAL_CYCLES    (`COARSE_CAL_NS / `CLOCK_PERIOD_NS)
`define FINE_CAL_CYCLES      (`FINE_CAL_NS / `CLOCK_PERIOD_NS)

`endif

//--- core/ref_clock_pkg.sv
// Purpose : shared types of the reference clock and synthesizer control
// Assumes : used with ref_clock_consts.svh
// Notes   : states are one-hot
package ref_clock_pkg;

    // ------------------------------------------------------------------
    // power and synthesizer sequence
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        st_osc_wait = 5'h01,
        st_coarse   = 5'h02,
        st_idle     = 5'h04,
        st_fine     = 5'h08,
        st_run      = 5'h10
    } synth_state_type;

endpackage

//--- core/synth_link_if.sv
// Purpose : carries calibration and clock divider signals inside the block
// Assumes : single clock domain
// Notes   : one modport per party
`timescale 1ns/10ps
interface synth_link_if;
    logic       cal_start;
    logic       cal_fine;
    logic       cal_busy;
    logic       cal_done;
    logic [2:0] div_sel;
    logic       div_run;
    logic       div_wave;

    modport main (output cal_start, output cal_fine, input cal_busy, input cal_done,
                  output div_sel, output div_run, input div_wave);
    modport cal  (input cal_start, input cal_fine, output cal_busy, output cal_done);
    modport div  (input div_sel, input div_run, output div_wave);
endinterface // synth_link_if

//--- core/vco_cal_timer.sv
// Purpose : times the coarse and fine vco calibration runs
// Assumes : cal_start is a one-cycle pulse while idle
// Notes   : cal_done pulses for one cycle at the end of a run
`timescale 1ns/10ps
`include "ref_clock_consts.svh"
module vco_cal_timer (
    input  wire logic clock,
    input  wire logic rst,
    synth_link_if.cal link
);
    localparam logic [11:0] COARSE_LAST = 12'(`COARSE_CAL_CYCLES - 1);
    localparam logic [11:0] FINE_LAST   = 12'(`FINE_CAL_CYCLES - 1);

    logic [11:0] count_r;
    logic        busy_r;
    logic        done_r;

    // ------------------------------------------------------------------
    // run counter: loads the length minus one on start, ends with a done pulse
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            count_r <= 12'h000;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (!busy_r && link.cal_start) begin
                count_r <= link.cal_fine ? FINE_LAST : COARSE_LAST;
                busy_r  <= 1'b1;
            end else if (busy_r) begin
                if (count_r == 12'h000) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end else begin
                    count_r <= count_r - 12'h001;
                end
            end
        end
    end

    assign link.cal_busy = busy_r;
    assign link.cal_done = done_r;
endmodule // vco_cal_timer

//--- test/clk_checks_props.sv
// Purpose: port level checks of the clock and synth control
// Assumes: byte address is register index times four
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module clk_checks (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pslverr,
    input wire logic        sleep_mode,
    input wire logic        xtal_stable,
    input wire logic        pll_in_range,
    input wire logic        ref_clock_output_gate,
    input wire logic        pll_start,
    input wire logic        vco_fine_cal,
    input wire logic        pll_lock,
    input wire logic [4:0]  synth_int,
    input wire logic [18:0] synth_frac
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // low byte write; the applied word may only move one or two edges after it
    wire lsb_wr = psel && penable && pwrite && paddr == 12'h024;
    AST_SLEEP_OFF: assert property (sleep_mode |=> !ref_clock_output_gate)
        else $error("clock gate open in sleep");
    AST_NO_XTAL: assert property (!xtal_stable |=> !ref_clock_output_gate)
        else $error("clock gate open before oscillator stable");
    AST_FINE_FIRST: assert property ($rose(pll_start) |-> vco_fine_cal)
        else $error("pll started without fine calibration");
    AST_WORD_HOLD: assert property (!$stable({synth_int, synth_frac}) |-> $past(lsb_wr) || $past(lsb_wr, 2))
        else $error("carrier word moved without low byte write");
    AST_LOCK_PLL: assert property (pll_lock |-> pll_start)
        else $error("lock shown with pll off");
    AST_LOCK_DROP: assert property (!pll_in_range |=> !pll_lock)
        else $error("lock held out of range");
    AST_BAD_ADDR: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    AST_ERR_ACCESS: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access phase");
    cover property (lsb_wr);
    cover property ($rose(pll_lock));
    cover property (sleep_mode ##1 !ref_clock_output_gate);
endmodule // clk_checks
bind ref_clock_and_synth_control clk_checks u_chk (.*);

//--- test/front_model.sv
// Purpose: oscillator, pll loop and supply seen by the block
// Assumes: levels change just after a rising edge
// Notes: range is reached one edge after fine calibration ends
`timescale 1ns/10ps
module front_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       pll_start,
    input  wire logic       vco_fine_cal,
    output logic            xtal_stable,
    output logic            pll_in_range,
    output logic      [7:0] supply_level
);
    logic [5:0] wait_r;
    // crystal reports stable 64 cycles after reset; a real part would take far longer
    always_ff @(posedge clock) begin
        wait_r       <= rst ? 6'h00 : wait_r + {5'h00, ~&wait_r};
        xtal_stable  <= &wait_r;
        pll_in_range <= pll_start && !vco_fine_cal;
    end
    assign supply_level = 8'h40; // below the threshold the bench programs
endmodule // front_model

//--- test/tb_top.sv
// Purpose: register and pin test of the clock and synth control
// Assumes: apb slave answers within 16 cycles
// Notes: coarse calibration runs its full length
`timescale 1ns/10ps
module tb_top;
    logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        sleep_mode = 1'b0, pll_request = 1'b0, pready, pslverr, xtal_stable, pll_in_range;
    logic        ref_clock_output_gate, ext_clock_select, pll_start, vco_coarse_cal, vco_fine_cal;
    logic        pll_lock, low_battery_irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'hf;
    logic [5:0]  io_in = 6'h00, io_out, io_oe_n;
    logic [7:0]  supply_level;
    logic [4:0]  synth_int;
    logic [18:0] synth_frac;
    logic [32:0] rd;
    int          err_total = 0, n_checks = 0;
    initial forever #5 clock = ~clock;
    ref_clock_and_synth_control i_dut (.*);
    front_model i_front (.*);
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        rd = {pslverr, prdata};
        {psel, penable} <= 2'b00;
        if (i == 16) begin
            err_total++;
            wrap_up;
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [32:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // outputs are read at the falling edge, clear of the update edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        repeat (lim) begin
            @(negedge clock);
            if (s === v) return;
        end
        err_total++;
        wrap_up;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rdchk(12'h164, 33'h0);
        rdchk(12'h190, 33'h0);
        rdchk(12'h3fe, 33'h100000000);
        wait_lvl(xtal_stable, 1'b1, 200);
        step(2);
        chk({ref_clock_output_gate, vco_coarse_cal}, 2'b11);
        @(posedge clock) sleep_mode <= 1'b1;
        step(2);
        chk(ref_clock_output_gate, 1'b0);
        @(posedge clock) sleep_mode <= 1'b0;
        apb(1'b1, 12'h190, 32'h1);
        step(2);
        chk({ref_clock_output_gate, io_oe_n[5], io_out[5]}, 3'b001);
        step(0);
        chk(io_out[5], 1'b0);
        apb(1'b1, 12'h190, 32'h7);
        step(2);
        chk(io_oe_n[5], 1'b1);
        apb(1'b1, 12'h164, 32'h10);
        apb(1'b1, 12'h01c, 32'hab);
        apb(1'b1, 12'h020, 32'hcd);
        step(2);
        chk({ext_clock_select, synth_int, synth_frac}, 25'h1000000);
        rdchk(12'h01c, 33'hab);
        apb(1'b1, 12'h024, 32'hef);
        step(2);
        chk({synth_int, synth_frac}, 24'habcdef);
        wait_lvl(vco_coarse_cal, 1'b0, 5000);
        @(posedge clock) pll_request <= 1'b1;
        step(2);
        chk({vco_fine_cal, pll_start}, 2'b11);
        wait_lvl(vco_fine_cal, 1'b0, 1200);
        apb(1'b1, 12'h18c, 32'h0102);
        apb(1'b1, 12'h188, 32'h180);
        step(2);
        chk({pll_lock, low_battery_irq, io_oe_n[1:0], io_out[1:0]}, 6'h33);
        wrap_up;
    end
endmodule // tb_top
